// ### verilog/mode_word_regs.svh
// named field positions, codes and timing counts for the mode-word block
// assumes a 50 MHz sys_clk; included by bare name from the design files
`ifndef MODE_WORD_REGS_SVH
`define MODE_WORD_REGS_SVH

// ----------------------------------------------------------------------
// bank-pin selection of the four words
// ----------------------------------------------------------------------
`define BA_MAIN        2'h0
`define BA_EXT_ONE     2'h1
`define BA_EXT_TWO     2'h2
`define BA_EXT_THREE   2'h3
`define WORD_RESET     14'h0000

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define F_BL_HI        2
`define F_BL_LO        0
`define F_BT           3
`define F_CL_HI        6
`define F_CL_LO        4
`define F_TEST         7
`define F_DLL_RST      8
`define F_WR_HI        11
`define F_WR_LO        9
`define F_DLL_OFF      0
`define F_REDUCED      1
`define F_TERM_LO      2
`define F_AL_HI        5
`define F_AL_LO        3
`define F_TERM_HI      6
`define F_CAL_HI       9
`define F_CAL_LO       7
`define F_STB_DIS      10
`define F_RO_STB       11
`define F_EXT_SR       7

// ----------------------------------------------------------------------
// codes
// ----------------------------------------------------------------------
`define BL_FOUR        3'h2
`define BL_EIGHT       3'h3
`define CAL_EXIT       3'h0
`define CAL_DRIVE_HI   3'h1
`define CAL_DRIVE_LO   3'h2
`define CAL_ADJUST     3'h4
`define CAL_DEFAULT    3'h7
`define ADJ_PU_UP      4'h1
`define ADJ_PU_DN      4'h2
`define ADJ_PD_UP      4'h4
`define ADJ_PD_DN      4'h8
`define ADJ_BOTH_UP    4'h5
`define ADJ_PU_DN_PD_UP 4'h6
`define ADJ_PU_UP_PD_DN 4'h9
`define ADJ_BOTH_DN    4'ha
`define LAST_BEAT      2'h3
`define STEP_MAX       4'hf
`define STEP_MIN       4'h0
`define STEP_DEFAULT   4'h8

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS  20
`define DRIVE_ON_DELAY_NS 40
`define DRIVE_ON_CYC   ((`DRIVE_ON_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### verilog/mode_word_pkg.sv
// types shared by the mode-word block
// assumes the constants header supplies all numbers
package mode_word_pkg;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [2:0]  ba;
    logic [13:0] addr;
    logic [7:0]  dq;
  } pin_bus_s;

  typedef enum logic [2:0] {
    CAL_IDLE,
    CAL_ON_WAIT,
    CAL_DRIVE,
    CAL_OFF_WAIT,
    CAL_ADJ,
    CAL_ADJ_WAIT,
    CAL_ADJ_BEATS
  } cal_state_e;

  typedef struct packed {
    logic       oe;
    logic [7:0] dq;
    logic       strobe;
    logic       strobe_n;
  } drive_out_s;

endpackage

// ### verilog/pin_sync.sv
// two-flop synchroniser for a bundle of pin levels
// assumes the bits are independent levels, not a coherent word
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = d;
    sync_nxt = meta_r;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign q = sync_r;

endmodule

// ### verilog/drive_step.sv
// saturating 16-step driver strength setting
// assumes inc, dec and load_default are one-cycle pulses from sys_clk logic
`timescale 1ns/1ps
`include "mode_word_regs.svh"

module drive_step (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // step requests
  input  wire logic       inc,
  input  wire logic       dec,
  input  wire logic       load_default,
  // setting
  output logic      [3:0] step
);

  logic [3:0] step_r;
  logic [3:0] step_nxt;

  always_comb begin
    step_nxt = step_r;
    if (load_default) begin
      step_nxt = `STEP_DEFAULT;
    end else if (inc && !dec && (step_r != `STEP_MAX)) begin
      step_nxt = step_r + 4'h1;
    end else if (dec && !inc && (step_r != `STEP_MIN)) begin
      step_nxt = step_r - 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      step_r <= `STEP_DEFAULT;
    end else begin
      step_r <= step_nxt;
    end
  end

  assign step = step_r;

  AST_STEP_SAT_TOP: assert property (@(posedge sys_clk) disable iff (srst)
    (step_r == 4'hf) && inc && !dec && !load_default |=> step_r == 4'hf)
    else $error("step passed the top of its range");

  AST_STEP_SAT_BOT: assert property (@(posedge sys_clk) disable iff (srst)
    (step_r == 4'h0) && dec && !inc && !load_default |=> step_r == 4'h0)
    else $error("step passed the bottom of its range");

endmodule

// ### verilog/mode_register_and_driver_calibration.sv
// mode-word decode, self-refresh dll control and driver calibration
// assumes pins are asynchronous to sys_clk and one data beat per sys_clk cycle
`timescale 1ns/1ps
`include "mode_word_regs.svh"

// Operation
// - burst length from bits 2:0, four or eight
// - burst type bit 3, latency bits 6:4
// - bit 8 dll reset, bit 7 test mode
// - write recovery count from bits 11:9
// - all-low command loads word chosen by banks
// - extended word one field decode
// - self refresh turns dll off, exit resets
// - extended word two bit 7 self-refresh rate
// - calibration control code selects mode
// - drive modes force data and strobe levels
// - drivers follow entry and exit after delay
// - single adjust codes step one driver
// - shared saturating 16-step setting
// - code sampled at additive plus latency minus one
// - read-only strobe disables mask, reads only
module mode_register_and_driver_calibration (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // command and address pins
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic        cke,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  // data pins, input side
  input  wire logic [7:0]  dq_in,
  // stored words
  output logic      [13:0] main_operating_word,
  output logic      [13:0] dll_drive_latency_word,
  output logic      [13:0] refresh_option_word,
  output logic      [13:0] spare_extended_word,
  // decoded mode state
  output logic             burst_eight,
  output logic             dll_active,
  output logic             dll_reset_pulse,
  output logic             self_refresh,
  output logic             write_byte_mask_en,
  output logic             read_only_strobe_drive,
  // driver calibration
  output logic [3:0]       pull_up_step,
  output logic [3:0]       pull_down_step,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  output logic             strobe_out,
  output logic             strobe_n_out,
  output logic             strobe_oe
);

  localparam int ON_CYC = `DRIVE_ON_CYC;

  // ----------------------------------------------------------------------
  // pin capture and command decode
  // ----------------------------------------------------------------------
  mode_word_pkg::pin_bus_s pins_raw;
  mode_word_pkg::pin_bus_s pins_s;
  logic                    cke_prev_r;
  logic                    self_refresh_r;
  logic                    cmd_low;
  logic                    mode_write;
  logic                    main_wr;
  logic                    ext1_wr;
  logic                    ext2_wr;
  logic                    ext3_wr;
  logic                    sr_entry;
  logic                    sr_exit;
  logic                    write_cmd;
  logic                    read_cmd;
  logic [2:0]              cal_code;

  assign pins_raw = {cs_n, ras_n, cas_n, we_n, cke, ba, addr, dq_in};

  pin_sync #(.WIDTH($bits(mode_word_pkg::pin_bus_s))) u_pin_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (pins_raw),
    .q       (pins_s)
  );

  assign cmd_low    = !pins_s.cs_n && !pins_s.ras_n && !pins_s.cas_n;
  // cke must be high on this and the previous edge; self-refresh entry instead needs we_n high with cke falling
  assign mode_write = cmd_low && !pins_s.we_n && pins_s.cke && cke_prev_r &&
                      !pins_s.ba[2];
  assign main_wr    = mode_write && (pins_s.ba[1:0] == `BA_MAIN);
  assign ext1_wr    = mode_write && (pins_s.ba[1:0] == `BA_EXT_ONE);
  assign ext2_wr    = mode_write && (pins_s.ba[1:0] == `BA_EXT_TWO);
  assign ext3_wr    = mode_write && (pins_s.ba[1:0] == `BA_EXT_THREE);
  assign sr_entry   = cmd_low && pins_s.we_n && cke_prev_r && !pins_s.cke;
  assign sr_exit    = self_refresh_r && !cke_prev_r && pins_s.cke;
  assign write_cmd  = !pins_s.cs_n && pins_s.ras_n && !pins_s.cas_n && !pins_s.we_n &&
                      pins_s.cke;
  assign read_cmd   = !pins_s.cs_n && pins_s.ras_n && !pins_s.cas_n && pins_s.we_n &&
                      pins_s.cke;
  assign cal_code   = pins_s.addr[`F_CAL_HI:`F_CAL_LO];

  // ----------------------------------------------------------------------
  // mode words and dll control
  // ----------------------------------------------------------------------
  logic [13:0] main_r,  main_nxt;
  logic [13:0] ext1_r,  ext1_nxt;
  logic [13:0] ext2_r,  ext2_nxt;
  logic [13:0] ext3_r,  ext3_nxt;
  logic        bl8_r,   bl8_nxt;
  logic        self_refresh_nxt;
  logic        dll_active_r,   dll_active_nxt;
  logic        dll_rst_r,      dll_rst_nxt;
  logic        mask_en_r,      mask_en_nxt;
  logic        ro_drive_r,     ro_drive_nxt;

  always_comb begin
    main_nxt         = main_r;
    ext1_nxt         = ext1_r;
    ext2_nxt         = ext2_r;
    ext3_nxt         = ext3_r;
    bl8_nxt          = bl8_r;
    self_refresh_nxt = self_refresh_r;
    dll_rst_nxt      = 1'b0;
    if (main_wr) begin
      main_nxt    = pins_s.addr;
      dll_rst_nxt = pins_s.addr[`F_DLL_RST];
      // unsupported length codes keep the previous length
      if (pins_s.addr[`F_BL_HI:`F_BL_LO] == `BL_EIGHT) begin
        bl8_nxt = 1'b1;
      end else if (pins_s.addr[`F_BL_HI:`F_BL_LO] == `BL_FOUR) begin
        bl8_nxt = 1'b0;
      end
    end
    if (ext1_wr) begin
      ext1_nxt = pins_s.addr;
    end
    if (ext2_wr) begin
      ext2_nxt = pins_s.addr;
    end
    if (ext3_wr) begin
      ext3_nxt = pins_s.addr;
    end
    if (sr_entry) begin
      self_refresh_nxt = 1'b1;
    end else if (sr_exit) begin
      self_refresh_nxt = 1'b0;
      dll_rst_nxt      = 1'b1;
    end
    // dll runs when enabled (bit clear) and not in self refresh
    dll_active_nxt = !ext1_nxt[`F_DLL_OFF] && !self_refresh_nxt;
    mask_en_nxt    = !ext1_nxt[`F_RO_STB];
    ro_drive_nxt   = ext1_r[`F_RO_STB] && read_cmd;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      main_r         <= `WORD_RESET;
      ext1_r         <= `WORD_RESET;
      ext2_r         <= `WORD_RESET;
      ext3_r         <= `WORD_RESET;
      bl8_r          <= 1'b0;
      cke_prev_r     <= 1'b0;
      self_refresh_r <= 1'b0;
      dll_active_r   <= 1'b0;
      dll_rst_r      <= 1'b0;
      mask_en_r      <= 1'b1;
      ro_drive_r     <= 1'b0;
    end else begin
      main_r         <= main_nxt;
      ext1_r         <= ext1_nxt;
      ext2_r         <= ext2_nxt;
      ext3_r         <= ext3_nxt;
      bl8_r          <= bl8_nxt;
      cke_prev_r     <= pins_s.cke;
      self_refresh_r <= self_refresh_nxt;
      dll_active_r   <= dll_active_nxt;
      dll_rst_r      <= dll_rst_nxt;
      mask_en_r      <= mask_en_nxt;
      ro_drive_r     <= ro_drive_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // driver calibration sequencer
  // ----------------------------------------------------------------------
  mode_word_pkg::cal_state_e state_r, state_nxt;
  mode_word_pkg::drive_out_s drv_r,   drv_nxt;
  logic [3:0] timer_r, timer_nxt;
  logic [3:0] wl_cnt_r, wl_cnt_nxt;
  logic [3:0] wl;
  logic [1:0] beat_r, beat_nxt;
  logic [3:0] code_r, code_nxt;
  logic       apply_r, apply_nxt;
  logic       dflt_r, dflt_nxt;
  logic       high_r, high_nxt;
  logic       pu_inc, pu_dec, pd_inc, pd_dec;

  // previously programmed additive latency is used, per the adjust timing
  assign wl = {1'b0, ext1_r[`F_AL_HI:`F_AL_LO]} + {1'b0, main_r[`F_CL_HI:`F_CL_LO]} - 4'h1;

  always_comb begin
    state_nxt  = state_r;
    timer_nxt  = timer_r;
    wl_cnt_nxt = wl_cnt_r;
    beat_nxt   = beat_r;
    code_nxt   = code_r;
    high_nxt   = high_r;
    apply_nxt  = 1'b0;
    dflt_nxt   = 1'b0;
    if (ext1_wr) begin
      case (cal_code)
        `CAL_EXIT: begin
          if ((state_r == mode_word_pkg::CAL_ON_WAIT) ||
              (state_r == mode_word_pkg::CAL_DRIVE)) begin
            state_nxt = mode_word_pkg::CAL_OFF_WAIT;
            timer_nxt = 4'(ON_CYC);
          end else if (state_r != mode_word_pkg::CAL_OFF_WAIT) begin
            state_nxt = mode_word_pkg::CAL_IDLE;
          end
        end
        `CAL_DRIVE_HI, `CAL_DRIVE_LO: begin
          high_nxt  = (cal_code == `CAL_DRIVE_HI);
          state_nxt = mode_word_pkg::CAL_ON_WAIT;
          timer_nxt = 4'(ON_CYC);
        end
        `CAL_ADJUST: begin
          state_nxt = mode_word_pkg::CAL_ADJ;
        end
        `CAL_DEFAULT: begin
          dflt_nxt = 1'b1;
        end
        default: begin
        end
      endcase
    end else begin
      case (state_r)
        mode_word_pkg::CAL_ON_WAIT: begin
          if (timer_r <= 4'h1) begin
            state_nxt = mode_word_pkg::CAL_DRIVE;
          end else begin
            timer_nxt = timer_r - 4'h1;
          end
        end
        mode_word_pkg::CAL_OFF_WAIT: begin
          if (timer_r <= 4'h1) begin
            state_nxt = mode_word_pkg::CAL_IDLE;
          end else begin
            timer_nxt = timer_r - 4'h1;
          end
        end
        mode_word_pkg::CAL_ADJ: begin
          if (write_cmd) begin
            beat_nxt = 2'h0;
            if (wl <= 4'h1) begin
              state_nxt = mode_word_pkg::CAL_ADJ_BEATS;
            end else begin
              state_nxt  = mode_word_pkg::CAL_ADJ_WAIT;
              wl_cnt_nxt = wl - 4'h1;
            end
          end
        end
        mode_word_pkg::CAL_ADJ_WAIT: begin
          if (wl_cnt_r <= 4'h1) begin
            state_nxt = mode_word_pkg::CAL_ADJ_BEATS;
          end else begin
            wl_cnt_nxt = wl_cnt_r - 4'h1;
          end
        end
        mode_word_pkg::CAL_ADJ_BEATS: begin
          // first beat ends in bit 3; burst type plays no part
          code_nxt = {code_r[2:0], pins_s.dq[0]};
          beat_nxt = beat_r + 2'h1;
          if (beat_r == `LAST_BEAT) begin
            apply_nxt = 1'b1;
            state_nxt = mode_word_pkg::CAL_ADJ;
          end
        end
        default: begin
        end
      endcase
    end
    drv_nxt.oe       = (state_nxt == mode_word_pkg::CAL_DRIVE) ||
                       (state_nxt == mode_word_pkg::CAL_OFF_WAIT);
    drv_nxt.dq       = (drv_nxt.oe && high_nxt) ? 8'hff : 8'h00;
    drv_nxt.strobe   = drv_nxt.oe && high_nxt;
    drv_nxt.strobe_n = drv_nxt.oe && !high_nxt;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r  <= mode_word_pkg::CAL_IDLE;
      drv_r    <= '0;
      timer_r  <= 4'h0;
      wl_cnt_r <= 4'h0;
      beat_r   <= 2'h0;
      code_r   <= 4'h0;
      apply_r  <= 1'b0;
      dflt_r   <= 1'b0;
      high_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      drv_r    <= drv_nxt;
      timer_r  <= timer_nxt;
      wl_cnt_r <= wl_cnt_nxt;
      beat_r   <= beat_nxt;
      code_r   <= code_nxt;
      apply_r  <= apply_nxt;
      dflt_r   <= dflt_nxt;
      high_r   <= high_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // adjust decode and shared step counters
  // ----------------------------------------------------------------------
  // any code not listed falls through all four terms and changes nothing
  assign pu_inc = apply_r && ((code_r == `ADJ_PU_UP) || (code_r == `ADJ_BOTH_UP) ||
                  (code_r == `ADJ_PU_UP_PD_DN));
  assign pu_dec = apply_r && ((code_r == `ADJ_PU_DN) || (code_r == `ADJ_PU_DN_PD_UP) ||
                  (code_r == `ADJ_BOTH_DN));
  assign pd_inc = apply_r && ((code_r == `ADJ_PD_UP) || (code_r == `ADJ_BOTH_UP) ||
                  (code_r == `ADJ_PU_DN_PD_UP));
  assign pd_dec = apply_r && ((code_r == `ADJ_PD_DN) || (code_r == `ADJ_PU_UP_PD_DN) ||
                  (code_r == `ADJ_BOTH_DN));

  drive_step u_pull_up (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .inc          (pu_inc),
    .dec          (pu_dec),
    .load_default (dflt_r),
    .step         (pull_up_step)
  );

  drive_step u_pull_down (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .inc          (pd_inc),
    .dec          (pd_dec),
    .load_default (dflt_r),
    .step         (pull_down_step)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign main_operating_word    = main_r;
  assign dll_drive_latency_word = ext1_r;
  assign refresh_option_word    = ext2_r;
  assign spare_extended_word    = ext3_r;
  assign burst_eight            = bl8_r;
  assign dll_active             = dll_active_r;
  assign dll_reset_pulse        = dll_rst_r;
  assign self_refresh           = self_refresh_r;
  assign write_byte_mask_en     = mask_en_r;
  assign read_only_strobe_drive = ro_drive_r;
  assign dq_out                 = drv_r.dq;
  assign dq_oe                  = drv_r.oe;
  assign strobe_out             = drv_r.strobe;
  assign strobe_n_out           = drv_r.strobe_n;
  assign strobe_oe              = drv_r.oe;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_BL_EIGHT: assert property (@(posedge sys_clk) disable iff (srst)
    main_wr && (pins_s.addr[2:0] == 3'h3) |=> bl8_r && burst_eight)
    else $error("burst length eight not taken");

  AST_MAIN_LOAD: assert property (@(posedge sys_clk) disable iff (srst)
    main_wr |=> main_operating_word == $past(pins_s.addr))
    else $error("main word not loaded");

  AST_EXT1_LOAD: assert property (@(posedge sys_clk) disable iff (srst)
    ext1_wr |=> (ext1_r == $past(pins_s.addr)) &&
                (dll_active == (!ext1_r[0] && !self_refresh_r)))
    else $error("extended word one not loaded");

  AST_SR_DLL: assert property (@(posedge sys_clk) disable iff (srst)
    sr_entry |=> !dll_active && self_refresh)
    else $error("dll still on in self refresh");

  AST_SR_EXIT_RESET: assert property (@(posedge sys_clk) disable iff (srst)
    sr_exit |=> dll_reset_pulse && !self_refresh ##1 !dll_reset_pulse || $past(main_wr))
    else $error("dll not reset on self refresh exit");

  AST_DRIVE_LEVELS: assert property (@(posedge sys_clk) disable iff (srst)
    dq_oe |-> (dq_out == (high_r ? 8'hff : 8'h00)) && (strobe_out == high_r) &&
              (strobe_n_out == !high_r))
    else $error("drive levels wrong");

  AST_DRIVE_ON: assert property (@(posedge sys_clk) disable iff (srst)
    ext1_wr && (cal_code == 3'h1) && (state_r == mode_word_pkg::CAL_IDLE)
    |=> !dq_oe ##ON_CYC dq_oe)
    else $error("drivers not on after drive delay");

  AST_RESERVED_ADJ: assert property (@(posedge sys_clk) disable iff (srst)
    apply_r && !(code_r inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha}) && !dflt_r
    |=> $stable(pull_up_step) && $stable(pull_down_step))
    else $error("reserved adjust code changed the step");

  AST_PU_UP: assert property (@(posedge sys_clk) disable iff (srst)
    apply_r && (code_r == 4'h1) && (pull_up_step != 4'hf) && !dflt_r
    |=> (pull_up_step == $past(pull_up_step) + 4'h1) && $stable(pull_down_step))
    else $error("pull-up raise code not applied");

  AST_BOTH_DN: assert property (@(posedge sys_clk) disable iff (srst)
    apply_r && (code_r == 4'ha) && (pull_up_step != 4'h0) && (pull_down_step != 4'h0) && !dflt_r
    |=> (pull_up_step == $past(pull_up_step) - 4'h1) &&
        (pull_down_step == $past(pull_down_step) - 4'h1))
    else $error("combined lower code not applied");

  AST_RO_STROBE: assert property (@(posedge sys_clk) disable iff (srst)
    ext1_wr && pins_s.addr[11] |=> !write_byte_mask_en)
    else $error("mask still on with read-only strobe");

  COV_DRIVE: cover property (@(posedge sys_clk) disable iff (srst) dq_oe && strobe_out);
  COV_ADJUST: cover property (@(posedge sys_clk) disable iff (srst) apply_r && (code_r != 4'h0));
  COV_SR_EXIT: cover property (@(posedge sys_clk) disable iff (srst) sr_exit);

endmodule

// ### dv/ctrl_model.sv
// controller model driving command, bank, address and data pins
// assumes the bench calls its tasks; pins change at the falling edge
`timescale 1ns/1ps
module ctrl_model (
  // clock
  input  wire logic               sys_clk,
  // pins
  output mode_word_pkg::pin_bus_s p
);
  // deselect with clock enable high long before any word write
  initial p = {5'h1f, 25'h0000000};
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(negedge sys_clk);
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = c;
    p.ba = b;
    p.addr = a; // whole word every time
    @(negedge sys_clk);
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = 4'hf;
    p.ba = ~b;
    p.addr = ~a; // released pins must not keep the old value
  endtask
  // write command, then the same four beats on every data line
  task automatic adjust(input logic [3:0] code);
    issue(4'h4, 3'h0, 14'h0000);
    p.dq = {8{code[3]}};
    for (int k = 2; k >= 0; k--) begin
      @(negedge sys_clk);
      p.dq = {8{code[k]}};
    end
    @(negedge sys_clk);
    p.dq = ~p.dq;
  endtask
  // self refresh entry, then cke held low until wake
  task automatic doze();
    @(negedge sys_clk);
    {p.cs_n, p.ras_n, p.cas_n, p.we_n, p.cke} = 5'h02;
    @(negedge sys_clk);
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = 4'hf;
  endtask
  task automatic wake();
    @(negedge sys_clk);
    p.cke = 1'b1;
  endtask
endmodule

// ### dv/mode_register_and_driver_calibration_test.sv
// self-checking bench for mode-word decode and driver calibration
// assumes the controller model owns every pin of the block
`timescale 1ns/1ps
`include "mode_word_regs.svh"
module mode_register_and_driver_calibration_test;
  typedef struct packed { logic [2:0] b; logic [13:0] a; logic e; } row_s;
  logic                    sys_clk = 1'b0;
  logic                    srst = 1'b1;
  int                      mismatches = 0;
  int                      n_tests = 0;
  mode_word_pkg::pin_bus_s p;
  logic [13:0]             main_operating_word, dll_drive_latency_word;
  logic [13:0]             refresh_option_word, spare_extended_word;
  logic [3:0]              pull_up_step, pull_down_step;
  logic [7:0]              dq_out;
  logic                    burst_eight, dll_active, dll_reset_pulse, self_refresh;
  logic                    write_byte_mask_en, read_only_strobe_drive;
  logic                    dq_oe, strobe_out, strobe_n_out, strobe_oe;
  wire  [3:0][13:0]        w = {spare_extended_word, refresh_option_word,
                                dll_drive_latency_word, main_operating_word};
  // bank, word, expected burst-eight
  row_s rows [5] = '{'{3'h2, 14'h0080, 1'b0}, '{3'h3, 14'h0000, 1'b0},
    '{3'h1, 14'h0000, 1'b0}, '{3'h0, 14'h0033, 1'b1}, '{3'h0, 14'h0a22, 1'b0}};
  // adjust code, then expected pull-up and pull-down steps
  logic [11:0] codes [4] = '{12'h198, 12'h689, 12'h389, 12'ha78};
  ctrl_model partner (.sys_clk, .p);
  mode_register_and_driver_calibration uut (.sys_clk, .srst, .cs_n(p.cs_n),
    .ras_n(p.ras_n), .cas_n(p.cas_n), .we_n(p.we_n), .cke(p.cke), .ba(p.ba),
    .addr(p.addr), .dq_in(p.dq), .main_operating_word, .dll_drive_latency_word,
    .refresh_option_word, .spare_extended_word, .burst_eight, .dll_active,
    .dll_reset_pulse, .self_refresh, .write_byte_mask_en, .read_only_strobe_drive,
    .pull_up_step, .pull_down_step, .dq_out, .dq_oe, .strobe_out, .strobe_n_out,
    .strobe_oe);
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial forever #10 sys_clk = ~sys_clk;
  initial begin
    cyc(12);
    srst = 1'b0;
    chk({pull_up_step, pull_down_step}, 8'h88);
    chk(write_byte_mask_en, 1'b1);
    $display("reset test done");
    foreach (rows[i]) begin
      partner.issue(4'h0, rows[i].b, rows[i].a);
      cyc(5);
      chk(w[rows[i].b[1:0]], rows[i].a);
      chk(burst_eight, rows[i].e);
    end
    $display("word table done");
    // bank bit 2 high must be ignored
    partner.issue(4'h0, 3'h5, 14'h0001);
    cyc(5);
    chk(dll_drive_latency_word, 14'h0000);
    chk(dll_active, 1'b1);
    $display("refused write done");
    for (int i = 0; i < 2; i++) begin
      partner.issue(4'h0, 3'h1, i ? 14'h0100 : 14'h0080);
      cyc(6);
      chk({dq_oe, strobe_oe, strobe_out, strobe_n_out, dq_out}, i ? 12'hd00 : 12'heff);
      partner.issue(4'h0, 3'h1, 14'h0000);
      cyc(6);
      chk({dq_oe, strobe_oe, strobe_out, strobe_n_out, dq_out}, 12'h000);
    end
    $display("drive modes done");
    foreach (codes[i]) begin
      partner.issue(4'h0, 3'h1, 14'h0200);
      partner.adjust(codes[i][11:8]);
      cyc(8);
      partner.issue(4'h0, 3'h1, 14'h0000);
      cyc(4);
      chk({pull_up_step, pull_down_step}, codes[i][7:0]);
    end
    partner.issue(4'h0, 3'h1, 14'h0380);
    partner.issue(4'h0, 3'h1, 14'h0800);
    cyc(6);
    chk({pull_up_step, pull_down_step}, 8'h88);
    chk(write_byte_mask_en, 1'b0);
    $display("adjust test done");
    partner.issue(4'h0, 3'h0, 14'h0122);
    cyc(2);
    chk(dll_reset_pulse, 1'b1);
    cyc(1);
    chk(dll_reset_pulse, 1'b0);
    partner.doze();
    cyc(4);
    chk({self_refresh, dll_active}, 2'h2);
    partner.wake();
    cyc(3);
    chk({self_refresh, dll_active, dll_reset_pulse}, 3'h3);
    cyc(1);
    chk(dll_reset_pulse, 1'b0);
    $display("dll test done");
    cyc(200);
    partner.issue(4'h5, 3'h0, 14'h0000);
    cyc(2);
    chk(read_only_strobe_drive, 1'b1);
    partner.issue(4'h4, 3'h0, 14'h0000);
    cyc(2);
    chk(read_only_strobe_drive, 1'b0);
    $display("read strobe test done");
    summarize();
  end
endmodule
